// ### logic/regulator_ctrl_regs.sv
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module regulator_ctrl_regs
	import regulator_ctrl_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [PADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic hw_control_1_i,
	input wire logic hw_control_2_i,
	input wire logic regulator_b_hw_assigned_i,
	input wire logic undervoltage_c_i,
	output logic [2:0] reg_b_sleep_slot_o,
	output logic reg_b_sleep_op_mode_o,
	output logic [4:0] reg_b_sleep_voltage_code_o,
	output logic [11:0] reg_b_sleep_mv_o,
	output sleep_plan_t reg_b_sleep_plan_o,
	output logic [1:0] reg_c_undervoltage_action_o,
	output logic [1:0] reg_c_hw_control_source_o,
	output logic reg_c_output_float_o,
	output logic reg_c_switch_select_o,
	output logic reg_c_low_power_level_o,
	output logic [2:0] reg_c_on_timeslot_o,
	output logic [1:0] reg_c_on_hw_enable_o,
	output c_applied_t regulator_c_applied_o,
	output logic regulator_c_shutdown_o,
	output logic system_reset_o,
	output logic irq_o
);

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	logic [15:0] b_sleep_q, c_general_q, c_on_q, c_sleep_q;
	logic [15:0] irq_status_q, irq_enable_q, irq_status_d, irq_clear, irq_set;
	logic [15:0] wdata, rd_val;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q, hit, setup, wr_en;

	assign setup = psel_i && !penable_i;
	assign wr_en = psel_i && penable_i && pready_q && pwrite_i;
	assign wdata = pwdata_i[15:0];

	always_comb begin
		hit = 1'b1;
		rd_val = 16'h0000;
		case (paddr_i)
			byte_addr(IDX_B_SLEEP): rd_val = b_sleep_q;
			byte_addr(IDX_C_GENERAL): rd_val = c_general_q;
			byte_addr(IDX_C_ON): rd_val = c_on_q;
			byte_addr(IDX_C_SLEEP): rd_val = c_sleep_q;
			byte_addr(IDX_IRQ_STATUS): rd_val = irq_status_q;
			byte_addr(IDX_IRQ_CLEAR): rd_val = 16'h0000;
			byte_addr(IDX_IRQ_ENABLE): rd_val = irq_enable_q;
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup && !hit;
			prdata_q <= (setup && !pwrite_i) ? {16'h0000, rd_val} : 32'h0000_0000;
		end
	end

	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign prdata_o = prdata_q;

	AST_APB_ONE_WAIT: assert property (setup |=> pready_o ##1 !pready_o)
		else $error("Access phase did not last exactly one cycle.");

	// ----------------------------------------
	// Sleep control of regulator b
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			b_sleep_q <= RST_B_SLEEP;
		end else if (wr_en && paddr_i == byte_addr(IDX_B_SLEEP)) begin
			b_sleep_q <= wdata & MASK_SLOT_REG;
		end
	end

	assign reg_b_sleep_slot_o = b_sleep_q[SLOT_HI:SLOT_LO];
	assign reg_b_sleep_op_mode_o = b_sleep_q[OPMODE_BIT];
	assign reg_b_sleep_voltage_code_o = b_sleep_q[VCODE_HI:VCODE_LO];

	AST_B_MODE_RESET: assert property ($fell(reset_i) |-> reg_b_sleep_op_mode_o)
		else $error("Sleep mode bit did not reset to low power.");

	AST_B_HELD: assert property (!wr_en |=> $stable(b_sleep_q))
		else $error("Sleep control changed without a write.");

	sleep_plan_t b_plan, b_plan_q;
	logic [11:0] b_mv_q;

	sleep_slot_decode u_b_slot (
		.slot_i(b_sleep_q[SLOT_HI:SLOT_LO]),
		.hw_assigned_i(regulator_b_hw_assigned_i),
		.plan_o(b_plan)
	);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			b_plan_q <= '0;
			b_mv_q <= 12'h000;
		end else begin
			b_plan_q <= b_plan;
			b_mv_q <= vcode_to_mv(b_sleep_q[VCODE_HI:VCODE_LO]);
		end
	end

	assign reg_b_sleep_plan_o = b_plan_q;
	assign reg_b_sleep_mv_o = b_mv_q;

	AST_B_SLOT_T3: assert property (reg_b_sleep_slot_o == SLP_T3
		|=> reg_b_sleep_plan_o.timeslot == 3'h3 && !reg_b_sleep_plan_o.disable_reg)
		else $error("Slot code 110 did not plan a transition in timeslot 3.");

	AST_B_DISABLE: assert property (reg_b_sleep_slot_o == 3'h2
		&& !regulator_b_hw_assigned_i
		|=> reg_b_sleep_plan_o.disable_reg && reg_b_sleep_plan_o.timeslot == 3'h4)
		else $error("Slot code 010 did not disable in timeslot 4.");

	AST_B_HW_SLEEP: assert property (reg_b_sleep_slot_o == 3'h5
		&& regulator_b_hw_assigned_i
		|=> reg_b_sleep_plan_o.hw_sleep && !reg_b_sleep_plan_o.disable_reg)
		else $error("Assigned regulator was disabled instead of entering sleep.");

	AST_B_VOLT: assert property (reg_b_sleep_voltage_code_o == 5'h0e
		|=> reg_b_sleep_mv_o == 12'd1600)
		else $error("Code 0Eh did not map to 1.60 V.");

	AST_B_VOLT_TOP: assert property (reg_b_sleep_voltage_code_o == 5'h1f
		&& $stable(b_sleep_q) |=> reg_b_sleep_mv_o == 12'd3300)
		else $error("Code 1Fh did not map to 3.30 V.");

	// ----------------------------------------
	// General, on and sleep control of regulator c
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			c_general_q <= RST_C_GENERAL;
		end else if (wr_en && paddr_i == byte_addr(IDX_C_GENERAL)) begin
			c_general_q <= wdata & MASK_C_GENERAL;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			c_on_q <= RST_C_ON;
		end else if (wr_en && paddr_i == byte_addr(IDX_C_ON)) begin
			c_on_q <= wdata & MASK_SLOT_REG;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			c_sleep_q <= RST_C_SLEEP;
		end else if (wr_en && paddr_i == byte_addr(IDX_C_SLEEP)) begin
			c_sleep_q <= wdata & MASK_SLOT_REG;
		end
	end

	assign reg_c_undervoltage_action_o = c_general_q[ERR_HI:ERR_LO];
	assign reg_c_hw_control_source_o = c_general_q[SRC_HI:SRC_LO];
	assign reg_c_output_float_o = c_general_q[FLT_BIT];
	assign reg_c_switch_select_o = c_general_q[SWI_BIT];
	assign reg_c_low_power_level_o = c_general_q[LP_BIT];

	AST_C_HELD: assert property (!wr_en |=> $stable(c_general_q))
		else $error("General control changed without a write.");

	logic [2:0] c_on_slot;
	logic [2:0] on_timeslot_q;
	logic [1:0] on_hw_enable_q;

	assign c_on_slot = c_on_q[SLOT_HI:SLOT_LO];

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			on_timeslot_q <= 3'h0;
			on_hw_enable_q <= 2'h0;
		end else begin
			on_timeslot_q <= (c_on_slot == ON_HWE1 || c_on_slot == ON_HWE2) ? ON_NEVER
				: c_on_slot;
			on_hw_enable_q <= {c_on_slot == ON_HWE2, c_on_slot == ON_HWE1};
		end
	end

	assign reg_c_on_timeslot_o = on_timeslot_q;
	assign reg_c_on_hw_enable_o = on_hw_enable_q;

	AST_C_ON_HWE: assert property (c_on_slot == ON_HWE2
		|=> reg_c_on_hw_enable_o == 2'h2 && reg_c_on_timeslot_o == 3'h0)
		else $error("On slot 111 did not select hardware enable 2.");

	// ----------------------------------------
	// Hardware control of regulator c
	// ----------------------------------------
	logic hw_active;
	op_mode_t on_mode;
	c_applied_t applied_d, applied_q;

	always_comb begin
		unique case (c_general_q[SRC_HI:SRC_LO])
			SRC_NONE: hw_active = 1'b0;
			SRC_1: hw_active = hw_control_1_i;
			SRC_2: hw_active = hw_control_2_i;
			SRC_ANY: hw_active = hw_control_1_i || hw_control_2_i;
		endcase
	end

	assign on_mode = c_on_q[OPMODE_BIT] ? OPM_LOW_POWER : OPM_NORMAL;

	always_comb begin
		applied_d.hw_active = hw_active;
		applied_d.vcode = c_on_q[VCODE_HI:VCODE_LO];
		applied_d.mode = on_mode;
		if (hw_active) begin
			if (c_general_q[HWV_BIT]) begin
				applied_d.vcode = c_sleep_q[VCODE_HI:VCODE_LO];
			end
			unique case (c_general_q[HWM_HI:HWM_LO])
				HWM_LP_A: applied_d.mode = OPM_LOW_POWER;
				HWM_OFF: applied_d.mode = OPM_OFF;
				HWM_LP_B: applied_d.mode = OPM_LOW_POWER;
				HWM_ON_MODE: applied_d.mode = on_mode;
			endcase
		end
		applied_d.mv = vcode_to_mv(applied_d.vcode);
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			applied_q <= '0;
		end else begin
			applied_q <= applied_d;
		end
	end

	assign regulator_c_applied_o = applied_q;

	AST_C_SRC_ANY: assert property (reg_c_hw_control_source_o == SRC_ANY
		&& (hw_control_1_i || hw_control_2_i) |=> regulator_c_applied_o.hw_active)
		else $error("Either input did not take hardware control.");

	AST_C_SRC_NONE: assert property (reg_c_hw_control_source_o == SRC_NONE
		|=> !regulator_c_applied_o.hw_active)
		else $error("Hardware control active with no source.");

	AST_C_VSEL: assert property (hw_active && c_general_q[HWV_BIT]
		|=> regulator_c_applied_o.vcode == $past(c_sleep_q[VCODE_HI:VCODE_LO]))
		else $error("Hardware control did not apply the sleep voltage code.");

	AST_C_MODE_OFF: assert property (hw_active
		&& c_general_q[HWM_HI:HWM_LO] == HWM_OFF |=> regulator_c_applied_o.mode == OPM_OFF)
		else $error("Hardware control mode 01 did not turn the regulator off.");

	AST_C_MODE_ON: assert property (hw_active
		&& c_general_q[HWM_HI:HWM_LO] == HWM_ON_MODE && c_on_q[OPMODE_BIT]
		|=> regulator_c_applied_o.mode == OPM_LOW_POWER)
		else $error("Mode code 11 did not follow the on mode bit.");

	// ----------------------------------------
	// Undervoltage response
	// ----------------------------------------
	logic shutdown_q, sys_reset_q;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			shutdown_q <= 1'b0;
			sys_reset_q <= 1'b0;
		end else begin
			shutdown_q <= undervoltage_c_i
				&& c_general_q[ERR_HI:ERR_LO] == ERR_SHUT_REG;
			sys_reset_q <= undervoltage_c_i
				&& c_general_q[ERR_HI:ERR_LO] == ERR_SHUT_SYS;
		end
	end

	assign regulator_c_shutdown_o = shutdown_q;
	assign system_reset_o = sys_reset_q;

	AST_UV_ACTION: assert property (undervoltage_c_i
		&& reg_c_undervoltage_action_o == ERR_SHUT_REG
		|=> regulator_c_shutdown_o && !system_reset_o
		##1 (!regulator_c_shutdown_o || $past(undervoltage_c_i)))
		else $error("Action 01 did not give a single regulator shutdown pulse.");

	AST_UV_SYS: assert property (undervoltage_c_i
		&& reg_c_undervoltage_action_o == ERR_SHUT_SYS |=> system_reset_o && !regulator_c_shutdown_o)
		else $error("Action 10 did not request a system reset.");

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	logic irq_q;

	assign irq_set = undervoltage_c_i ? (16'h0001 << IRQ_UV_BIT) : 16'h0000;
	assign irq_clear = (wr_en && paddr_i == byte_addr(IDX_IRQ_CLEAR)) ? (wdata & MASK_IRQ)
		: 16'h0000;
	assign irq_status_d = (irq_status_q & ~irq_clear) | irq_set;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			irq_status_q <= RST_IRQ;
		end else begin
			irq_status_q <= irq_status_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			irq_enable_q <= RST_IRQ;
		end else if (wr_en && paddr_i == byte_addr(IDX_IRQ_ENABLE)) begin
			irq_enable_q <= wdata & MASK_IRQ;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_status_q & irq_enable_q);
		end
	end

	assign irq_o = irq_q;

	AST_UV_IRQ: assert property (undervoltage_c_i |=> irq_status_q[IRQ_UV_BIT])
		else $error("Undervoltage event did not set its status bit.");

	AST_UV_IRQ_OUT: assert property (undervoltage_c_i && irq_enable_q[IRQ_UV_BIT]
		&& !(wr_en && paddr_i == byte_addr(IDX_IRQ_ENABLE)) |=> ##1 irq_o)
		else $error("Enabled undervoltage did not raise the interrupt line.");

endmodule

// ### logic/regulator_ctrl_pkg.sv
// Operation
// - Sleep slot 000 means transition in timeslot 5, 110 slot 3, 111 slot 1; reset 000.
// - Sleep slot codes 001 to 101 disable the regulator in timeslots 5 down to 1.
// - With a hardware enable assigned, codes 001 to 101 pick the sleep entry timeslot.
// - Sleep mode bit 8: 0 normal, 1 low power; resets to 1.
// - Voltage code 00h-0Eh is 0.90-1.60 V by 50 mV, 0Fh-1Fh 1.70-3.30 V by 100 mV.
// - Undervoltage action: 00 ignore, 01 regulator off, 10 system reset, 11 reserved.
// - Every undervoltage event sets the interrupt status bit, whatever the action setting; irq_o rises only if its enable bit is set.
// - Hardware control source: 00 none, 01 input 1, 10 input 2, 11 either input.
// - Under hardware control bit 10 picks on voltage code (0) or sleep code (1).
// - Hardware control mode: 00 and 10 low power, 01 off, 11 on mode; resets 10.
// - Bit 7: 0 discharges the disabled output, 1 leaves it floating.
// - Bit 0 picks low power level: 0 is 50 mA, 1 is 20 mA.
// - On slot: 000 never, 001-101 timeslots 1-5, 110/111 hardware enable 1/2.
// - On mode bit: 0 normal, 1 low power; used when hardware mode code is 11.
package regulator_ctrl_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int PADDR_W = 18;
	localparam logic [15:0] IDX_B_SLEEP = 16'h4076;
	localparam logic [15:0] IDX_C_GENERAL = 16'h4077;
	localparam logic [15:0] IDX_C_ON = 16'h4078;
	localparam logic [15:0] IDX_C_SLEEP = 16'h4079;
	localparam logic [15:0] IDX_IRQ_STATUS = 16'h4080;
	localparam logic [15:0] IDX_IRQ_CLEAR = 16'h4081;
	localparam logic [15:0] IDX_IRQ_ENABLE = 16'h4082;

	localparam logic [15:0] RST_B_SLEEP = 16'h0100;
	localparam logic [15:0] RST_C_GENERAL = 16'h0200;
	localparam logic [15:0] RST_C_ON = 16'h0000;
	localparam logic [15:0] RST_C_SLEEP = 16'h0000;
	localparam logic [15:0] RST_IRQ = 16'h0000;

	localparam logic [15:0] MASK_SLOT_REG = 16'he11f;
	localparam logic [15:0] MASK_C_GENERAL = 16'hdfc1;
	localparam logic [15:0] MASK_IRQ = 16'h0001;
	localparam int IRQ_UV_BIT = 0;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int SLOT_HI = 15;
	localparam int SLOT_LO = 13;
	localparam int OPMODE_BIT = 8;
	localparam int VCODE_HI = 4;
	localparam int VCODE_LO = 0;
	localparam int ERR_HI = 15;
	localparam int ERR_LO = 14;
	localparam int SRC_HI = 12;
	localparam int SRC_LO = 11;
	localparam int HWV_BIT = 10;
	localparam int HWM_HI = 9;
	localparam int HWM_LO = 8;
	localparam int FLT_BIT = 7;
	localparam int SWI_BIT = 6;
	localparam int LP_BIT = 0;

	// ----------------------------------------
	// Field codes
	// ----------------------------------------
	localparam logic [2:0] SLP_T5 = 3'h0;
	localparam logic [2:0] SLP_T3 = 3'h6;
	localparam logic [2:0] SLP_T1 = 3'h7;
	localparam logic [2:0] SLP_DIS_FIRST = 3'h1;
	localparam logic [2:0] SLP_DIS_LAST = 3'h5;
	localparam logic [2:0] SLP_DIS_BASE = 3'h6;
	localparam logic [2:0] ON_NEVER = 3'h0;
	localparam logic [2:0] ON_HWE1 = 3'h6;
	localparam logic [2:0] ON_HWE2 = 3'h7;
	localparam logic [1:0] ERR_SHUT_REG = 2'h1;
	localparam logic [1:0] ERR_SHUT_SYS = 2'h2;
	localparam logic [1:0] SRC_NONE = 2'h0;
	localparam logic [1:0] SRC_1 = 2'h1;
	localparam logic [1:0] SRC_2 = 2'h2;
	localparam logic [1:0] SRC_ANY = 2'h3;
	localparam logic [1:0] HWM_LP_A = 2'h0;
	localparam logic [1:0] HWM_OFF = 2'h1;
	localparam logic [1:0] HWM_LP_B = 2'h2;
	localparam logic [1:0] HWM_ON_MODE = 2'h3;

	// ----------------------------------------
	// Voltage scale
	// ----------------------------------------
	localparam logic [4:0] VCODE_SPLIT = 5'h0f;
	localparam int VLOW_BASE_MV = 900;
	localparam int VLOW_STEP_MV = 50;
	localparam int VHIGH_BASE_MV = 1700;
	localparam int VHIGH_STEP_MV = 100;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {OPM_NORMAL, OPM_LOW_POWER, OPM_OFF} op_mode_t;

	typedef struct packed {
		logic [2:0] timeslot;
		logic disable_reg;
		logic hw_sleep;
	} sleep_plan_t;

	typedef struct packed {
		logic hw_active;
		logic [4:0] vcode;
		op_mode_t mode;
		logic [11:0] mv;
	} c_applied_t;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [PADDR_W-1:0] byte_addr(input logic [15:0] idx);
		return {idx, 2'b00};
	endfunction

	function automatic logic [11:0] vcode_to_mv(input logic [4:0] code);
		if (code < VCODE_SPLIT) begin
			return 12'(VLOW_BASE_MV + VLOW_STEP_MV * int'(code));
		end
		return 12'(VHIGH_BASE_MV + VHIGH_STEP_MV * int'(code - VCODE_SPLIT));
	endfunction

endpackage

// ### logic/sleep_slot_decode.sv
`timescale 1ns/1ps
module sleep_slot_decode
	import regulator_ctrl_pkg::*;
(
	input wire logic [2:0] slot_i,
	input wire logic hw_assigned_i,
	output sleep_plan_t plan_o
);

	// ----------------------------------------
	// Slot decode
	// ----------------------------------------
	logic in_dis_range;

	assign in_dis_range = (slot_i >= SLP_DIS_FIRST) && (slot_i <= SLP_DIS_LAST);

	always_comb begin
		plan_o = '0;
		if (in_dis_range) begin
			plan_o.timeslot = SLP_DIS_BASE - slot_i;
			plan_o.disable_reg = !hw_assigned_i;
			plan_o.hw_sleep = hw_assigned_i;
		end else if (slot_i == SLP_T3) begin
			plan_o.timeslot = 3'h3;
		end else if (slot_i == SLP_T1) begin
			plan_o.timeslot = 3'h1;
		end else begin
			plan_o.timeslot = 3'h5;
		end
	end

endmodule

// ### verif/tb_regulator_sleep_hwc_control_regs.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
	$display("FAIL %s exp %0h got %0h", n, e, g); end end
module tb_regulator_sleep_hwc_control_regs
	import regulator_ctrl_pkg::*;
;
	localparam logic [17:0] A_BS = 18'h101d8;
	localparam logic [17:0] A_CG = 18'h101dc;
	localparam logic [17:0] A_CO = 18'h101e0;
	localparam logic [17:0] A_CS = 18'h101e4;
	localparam logic [17:0] A_ST = 18'h10200;
	localparam logic [17:0] A_CL = 18'h10204;
	localparam logic [17:0] A_EN = 18'h10208;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [PADDR_W-1:0] paddr_i = '0;
	logic [31:0] pwdata_i = '0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic h1 = 1'b0;
	logic h2 = 1'b0;
	logic asg = 1'b0;
	logic uv = 1'b0;
	logic [2:0] b_slot;
	logic b_mode;
	logic [4:0] b_vcode;
	logic [11:0] b_mv;
	sleep_plan_t b_plan;
	logic [1:0] c_act;
	logic [1:0] c_src;
	logic c_flt;
	logic c_swi;
	logic c_lp;
	logic [2:0] c_ts;
	logic [1:0] c_hwe;
	c_applied_t c_app;
	logic c_shut;
	logic sys_rst;
	logic irq_o;
	int error_cnt = 0;
	int tests_run = 0;
	logic [31:0] rdv;
	logic er;

	regulator_ctrl_regs i_regulator_ctrl_regs (.clk_i(clk_i), .reset_i(reset_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.hw_control_1_i(h1), .hw_control_2_i(h2), .regulator_b_hw_assigned_i(asg),
		.undervoltage_c_i(uv), .reg_b_sleep_slot_o(b_slot), .reg_b_sleep_op_mode_o(b_mode),
		.reg_b_sleep_voltage_code_o(b_vcode), .reg_b_sleep_mv_o(b_mv),
		.reg_b_sleep_plan_o(b_plan), .reg_c_undervoltage_action_o(c_act),
		.reg_c_hw_control_source_o(c_src), .reg_c_output_float_o(c_flt),
		.reg_c_switch_select_o(c_swi), .reg_c_low_power_level_o(c_lp),
		.reg_c_on_timeslot_o(c_ts), .reg_c_on_hw_enable_o(c_hwe),
		.regulator_c_applied_o(c_app), .regulator_c_shutdown_o(c_shut),
		.system_reset_o(sys_rst), .irq_o(irq_o));

	// ----------------------------------------
	// Clock, bus tasks and helpers
	// ----------------------------------------
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1);
		`CHK("wait", 1, n)
		rdv = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic tick();
		@(posedge clk_i);
		#1;
	endtask

	function automatic logic [11:0] emv(input int v);
		return (v < 15) ? 12'(900 + 50 * v) : 12'(1700 + 100 * (v - 15));
	endfunction

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		apb(1'b0, A_BS, 0);
		`CHK("b_sleep", 32'h0100, rdv)
		apb(1'b0, A_CG, 0);
		`CHK("c_general", 32'h0200, rdv)
		`CHK("b_plan", 5'b10100, b_plan)
		`CHK("b_mv", 12'd900, b_mv)
		`CHK("c_src", 2'b00, c_src)
	endtask

	task automatic t_sleep_b();
		logic [2:0] ts;
		logic dis;
		int v;
		for (int s = 0; s < 8; s++) begin
			for (int a = 0; a < 2; a++) begin
				v = s * 4 + a * ((s == 3) ? 2 : 3);
				@(posedge clk_i);
				asg <= a[0];
				apb(1'b1, A_BS, {16'h0, s[2:0], 4'hf, a[0], 3'h7, v[4:0]});
				tick();
				ts = (s == 0) ? 3'd5 : (s == 6) ? 3'd3 : (s == 7) ? 3'd1 : 3'(6 - s);
				dis = (s >= 1 && s <= 5);
				`CHK("plan", {ts, dis & ~a[0], dis & a[0]}, b_plan)
				`CHK("b_mode", a[0], b_mode)
				`CHK("b_fields", {s[2:0], v[4:0]}, {b_slot, b_vcode})
				`CHK("b_mv", emv(v), b_mv)
				apb(1'b0, A_BS, 0);
				`CHK("b_read", {16'h0, s[2:0], 4'h0, a[0], 3'h0, v[4:0]}, rdv)
			end
		end
	endtask

	task automatic t_general();
		apb(1'b1, A_CG, 32'h0000ffff);
		tick();
		`CHK("flags", 5'h1f, {c_flt, c_swi, c_lp, c_src})
		apb(1'b0, A_CG, 0);
		`CHK("c_read", 32'hdfc1, rdv)
		apb(1'b1, 18'h10300, 32'h0);
		`CHK("unmapped_err", 1'b1, er)
		tick();
		`CHK("kept", 5'h1f, {c_flt, c_swi, c_lp, c_src})
		apb(1'b1, A_CG, 32'h0);
		tick();
		`CHK("cleared", 5'h00, {c_flt, c_swi, c_lp, c_src})
	endtask

	task automatic t_on_slot();
		for (int s = 0; s < 8; s++) begin
			apb(1'b1, A_CO, {16'h0, s[2:0], 13'h0});
			tick();
			`CHK("on_ts", (s >= 1 && s <= 5) ? 3'(s) : 3'd0, c_ts)
			`CHK("on_hwe", {s == 7, s == 6}, c_hwe)
		end
	endtask

	task automatic t_uv();
		for (int a = 0; a < 4; a++) begin
			apb(1'b1, A_CG, {16'h0, a[1:0], 14'h0});
			apb(1'b1, A_EN, {31'h0, a != 3});
			`CHK("c_act", a[1:0], c_act)
			@(posedge clk_i);
			uv <= 1'b1;
			@(posedge clk_i);
			uv <= 1'b0;
			#1;
			`CHK("shutdown", a == 1, c_shut)
			`CHK("sys_reset", a == 2, sys_rst)
			tick();
			`CHK("pulse_end", 2'b00, {c_shut, sys_rst})
			`CHK("irq", a != 3, irq_o)
			apb(1'b0, A_ST, 0);
			`CHK("status", 32'h1, rdv)
			apb(1'b1, A_CL, 32'h1);
			apb(1'b0, A_ST, 0);
			`CHK("status_clr", 32'h0, rdv)
			tick();
			`CHK("irq_clr", 1'b0, irq_o)
		end
	endtask

	task automatic t_hw();
		logic act;
		op_mode_t em;
		op_mode_t om;
		apb(1'b1, A_CS, 32'h0010);
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, A_CO, {23'h0, s[0], 8'h03});
			om = s[0] ? OPM_LOW_POWER : OPM_NORMAL;
			for (int m = 0; m < 4; m++) begin
				apb(1'b1, A_CG, {16'h0, 3'h0, s[1:0], m[0], m[1:0], 8'h00});
				for (int h = 0; h < 4; h++) begin
					@(posedge clk_i);
					h1 <= h[0];
					h2 <= h[1];
					tick();
					tick();
					act = (s == 1 && h[0]) || (s == 2 && h[1]) || (s == 3 && h != 0);
					em = !act ? om : (m == 1) ? OPM_OFF : (m == 3) ? om : OPM_LOW_POWER;
					`CHK("hw_active", act, c_app.hw_active)
					`CHK("vcode", (act && m[0]) ? 5'h10 : 5'h03, c_app.vcode)
					`CHK("mv", (act && m[0]) ? 12'd1800 : 12'd1050, c_app.mv)
					`CHK("mode", em, c_app.mode)
				end
			end
		end
	endtask

	initial begin
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		t_reset();
		t_sleep_b();
		t_general();
		t_on_slot();
		t_uv();
		t_hw();
		complete_run();
	end

	initial begin
		#1000000;
		error_cnt++;
		complete_run();
	end
endmodule
